// ==== core/bwt_pkg.sv ====
// Purpose: shared constants and types of the base tick watchdog timer
// Assumes: 100 MHz mclk, APB with 32-bit data, index-based register map
// Notes: byte address of a register is four times its index
package bwt_pkg;

  // -----------------------------------------------
  // register map (indices)
  // -----------------------------------------------
  localparam logic [7:0] BWT_IDX_CTRL = 8'hD3;
  localparam logic [7:0] BWT_IDX_COUNT = 8'hFD;
  localparam logic [7:0] BWT_IDX_STAT = 8'hE0;
  localparam logic [7:0] BWT_IDX_MASK = 8'hE1;

  // -----------------------------------------------
  // reset values and field codes
  // -----------------------------------------------
  localparam logic [7:0] BWT_CTRL_RST = 8'h00;
  localparam logic [7:0] BWT_COUNT_RST = 8'h00;
  localparam logic [2:0] BWT_EV_RST = 3'h0;
  localparam logic [3:0] BWT_WD_OFF_KEY = 4'hA;
  localparam logic [1:0] BWT_SEL_4096 = 2'h0;
  localparam logic [1:0] BWT_SEL_1024 = 2'h1;
  localparam logic [1:0] BWT_SEL_128 = 2'h2;
  localparam int BWT_DIV_SLOW = 4096;
  localparam int BWT_DIV_MID = 1024;
  localparam int BWT_DIV_FAST = 128;
  localparam int BWT_CNT_MSB = 7;

  // event bit positions in status and mask
  localparam int BWT_EV_STAB = 0;
  localparam int BWT_EV_OVF = 1;
  localparam int BWT_EV_WAKE = 2;
  localparam int BWT_EV_W = 3;

  // control register layout
  typedef struct packed {
    logic [3:0] wd_key;
    logic [1:0] div_sel;
    logic clr_cnt;
    logic clr_div;
  } bwt_ctrl_t;

  typedef enum {
    BWT_ST_RSTAB,
    BWT_ST_RUN,
    BWT_ST_STOP,
    BWT_ST_WSTAB
  } bwt_state_t;

endpackage

// ==== core/bwt_divider.sv ====
// Purpose: prescaler producing the counter tick
// Assumes: division ratios are powers of two
// Notes: tick is one mclk wide, combinational from the stage count
`timescale 1ns/1ps
`default_nettype none
module bwt_divider import bwt_pkg::*; #(
  parameter int DIV_SLOW = BWT_DIV_SLOW,
  parameter int DIV_MID = BWT_DIV_MID,
  parameter int DIV_FAST = BWT_DIV_FAST
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronised reset
  input wire logic run, // oscillator running
  input wire logic clr, // clear divider stages
  input wire logic [1:0] sel, // division select
  output logic tick // one-cycle tick
);
  localparam int W = $clog2(DIV_SLOW);

  logic [W-1:0] stage;
  logic [W-1:0] next_stage;

  // mask of stages that must all be one for a tick
  function automatic logic [W-1:0] sel_mask(input logic [1:0] s);
    case (s)
      BWT_SEL_4096: sel_mask = W'(DIV_SLOW - 1);
      BWT_SEL_1024: sel_mask = W'(DIV_MID - 1);
      default: sel_mask = W'(DIV_FAST - 1);
    endcase
  endfunction

  // ratio taken from the low stages of one chain
  assign tick = run && ((stage & sel_mask(sel)) == sel_mask(sel));

  // stage chain, frozen while the oscillator is stopped
  always_comb begin
    next_stage = stage;
    if (clr) begin
      next_stage = '0;
    end else if (run) begin
      next_stage = stage + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

endmodule
`default_nettype wire

// ==== core/bwt_top.sv ====
// Purpose: base tick watchdog and oscillator stabilisation timer
// Assumes: APB slave, zero wait states, one clock domain
// Notes: wdt_reset_req is a pulse; the system turns it into arst_n
`timescale 1ns/1ps
`default_nettype none
module bwt_top import bwt_pkg::*; #(
  parameter int DIV_SLOW = BWT_DIV_SLOW,
  parameter int DIV_MID = BWT_DIV_MID,
  parameter int DIV_FAST = BWT_DIV_FAST
) (
  input wire logic mclk, // 100 MHz clock
  input wire logic arst_n, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic stop_enter, // cpu executes stop
  input wire logic ext_wake, // external interrupt
  output logic cpu_clk_en, // cpu clock gate
  output logic stab_done, // stabilisation over
  output logic wdt_reset_req, // system reset request
  output logic irq // level interrupt
);

  // -----------------------------------------------
  // reset release
  // -----------------------------------------------
  logic rst_s1;
  logic rst_n;

  // two stages so the release is clean against mclk
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // -----------------------------------------------
  // bus decode
  // -----------------------------------------------
  logic setup_ph;
  logic acc_ph;
  logic wr_acc;
  logic [7:0] idx;

  // index of a word address, all ones when the address is not word aligned
  function automatic logic [7:0] reg_idx(input logic [11:0] a);
    if (a[1:0] != 2'h0) begin
      reg_idx = 8'hFF;
    end else begin
      reg_idx = a[9:2];
    end
  endfunction

  // true for the four words this block answers
  function automatic logic reg_hit(input logic [11:0] a);
    logic [7:0] i;
    i = reg_idx(a);
    reg_hit = (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
              (i == BWT_IDX_CTRL || i == BWT_IDX_COUNT ||
               i == BWT_IDX_STAT || i == BWT_IDX_MASK);
  endfunction

  assign setup_ph = psel && !penable;
  assign acc_ph = psel && penable;
  assign idx = reg_idx(paddr);
  // no wait states: every access ends in its first cycle
  assign pready = 1'b1;
  assign wr_acc = acc_ph && pwrite && reg_hit(paddr);

  // -----------------------------------------------
  // control register
  // -----------------------------------------------
  bwt_ctrl_t ctrl;
  bwt_ctrl_t next_ctrl;
  bwt_ctrl_t wr_ctrl;
  logic ctrl_wr;
  logic sw_clr_cnt;
  logic sw_clr_div;
  logic wd_en;

  assign wr_ctrl = bwt_ctrl_t'(pwdata[7:0]);
  assign ctrl_wr = wr_acc && idx == BWT_IDX_CTRL;
  // clear bits are strobes, never stored
  assign sw_clr_cnt = ctrl_wr && wr_ctrl.clr_cnt;
  assign sw_clr_div = ctrl_wr && wr_ctrl.clr_div;
  // only the exact key turns the watchdog off
  assign wd_en = ctrl.wd_key != BWT_WD_OFF_KEY;

  // key and divider field written, strobes read back zero
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl.wd_key = wr_ctrl.wd_key;
      next_ctrl.div_sel = wr_ctrl.div_sel;
    end
    next_ctrl.clr_cnt = 1'b0;
    next_ctrl.clr_div = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= bwt_ctrl_t'(BWT_CTRL_RST);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // -----------------------------------------------
  // operating state
  // -----------------------------------------------
  bwt_state_t state;
  bwt_state_t next_state;
  logic [7:0] count;
  logic stab_hit;
  logic wake_go;
  logic run_osc;
  logic [1:0] eff_sel;
  logic next_cpu_clk_en;

  // stabilisation ends on the top counter bit
  assign stab_hit = (state == BWT_ST_RSTAB || state == BWT_ST_WSTAB) &&
                    count[BWT_CNT_MSB];
  assign wake_go = state == BWT_ST_STOP && ext_wake;
  // oscillator is off during stop, so nothing counts
  assign run_osc = state != BWT_ST_STOP;
  // reset stabilisation ignores the control field
  assign eff_sel = (state == BWT_ST_RSTAB) ? BWT_SEL_4096 : ctrl.div_sel;

  always_comb begin
    next_state = state;
    case (state)
      BWT_ST_RSTAB: begin
        if (stab_hit) begin
          next_state = BWT_ST_RUN;
        end
      end
      BWT_ST_RUN: begin
        if (stop_enter) begin
          next_state = BWT_ST_STOP;
        end
      end
      BWT_ST_STOP: begin
        if (wake_go) begin
          next_state = BWT_ST_WSTAB;
        end
      end
      BWT_ST_WSTAB: begin
        if (stab_hit) begin
          next_state = BWT_ST_RUN;
        end
      end
      default: begin
        next_state = BWT_ST_RSTAB;
      end
    endcase
    next_cpu_clk_en = next_state == BWT_ST_RUN;
  end

  // a system reset always begins with stabilisation
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= BWT_ST_RSTAB;
      cpu_clk_en <= 1'b0;
    end else begin
      state <= next_state;
      cpu_clk_en <= next_cpu_clk_en;
    end
  end

  // -----------------------------------------------
  // prescaler and counter
  // -----------------------------------------------
  logic tick;
  logic [7:0] next_count;
  logic ovf;
  logic next_wdt_req;
  logic next_stab_done;

  bwt_divider #(
    .DIV_SLOW(DIV_SLOW),
    .DIV_MID(DIV_MID),
    .DIV_FAST(DIV_FAST)
  ) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(run_osc),
    .clr(sw_clr_div || wake_go),
    .sel(eff_sel),
    .tick(tick)
  );

  // overflow out of bit 7 only counts once code runs
  assign ovf = tick && count == 8'hFF && state == BWT_ST_RUN;

  // software clear beats a tick in the same cycle
  always_comb begin
    next_count = count;
    if (sw_clr_cnt || wake_go) begin
      next_count = 8'h00;
    end else if (tick) begin
      next_count = count + 8'h01;
    end
    next_wdt_req = ovf && wd_en;
    next_stab_done = stab_hit;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= BWT_COUNT_RST;
      wdt_reset_req <= 1'b0;
      stab_done <= 1'b0;
    end else begin
      count <= next_count;
      wdt_reset_req <= next_wdt_req;
      stab_done <= next_stab_done;
    end
  end

  // -----------------------------------------------
  // event status, mask and interrupt
  // -----------------------------------------------
  logic [BWT_EV_W-1:0] stat;
  logic [BWT_EV_W-1:0] mask;
  logic [BWT_EV_W-1:0] ev;
  logic [BWT_EV_W-1:0] next_stat;
  logic [BWT_EV_W-1:0] next_mask;
  logic next_irq;

  assign ev[BWT_EV_STAB] = stab_hit;
  assign ev[BWT_EV_OVF] = ovf;
  assign ev[BWT_EV_WAKE] = wake_go;

  // write-one-to-clear; a new event wins over the clear
  always_comb begin
    next_stat = stat;
    next_mask = mask;
    if (wr_acc && idx == BWT_IDX_STAT) begin
      next_stat = stat & ~pwdata[BWT_EV_W-1:0];
    end
    if (wr_acc && idx == BWT_IDX_MASK) begin
      next_mask = pwdata[BWT_EV_W-1:0];
    end
    next_stat = next_stat | ev;
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stat <= BWT_EV_RST;
      mask <= BWT_EV_RST;
      irq <= 1'b0;
    end else begin
      stat <= next_stat;
      mask <= next_mask;
      irq <= next_irq;
    end
  end

  // -----------------------------------------------
  // read data
  // -----------------------------------------------
  logic [31:0] next_prdata;
  logic next_slverr;

  // sampled in setup so read data is a flop in access
  always_comb begin
    next_prdata = prdata;
    next_slverr = 1'b0;
    if (setup_ph) begin
      next_slverr = !reg_hit(paddr);
      case (reg_idx(paddr))
        BWT_IDX_CTRL: next_prdata = {24'h000000, 8'(ctrl)};
        BWT_IDX_COUNT: next_prdata = {24'h000000, count};
        BWT_IDX_STAT: next_prdata = {29'h0000000, stat};
        BWT_IDX_MASK: next_prdata = {29'h0000000, mask};
        default: next_prdata = 32'h00000000;
      endcase
      if (!reg_hit(paddr)) begin
        next_prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_slverr;
    end
  end

  // -----------------------------------------------
  // checks
  // -----------------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_write(int b);
    ctrl_wr && pwdata[b];
  endsequence
  sequence s_stab_hit;
    (state == BWT_ST_RSTAB || state == BWT_ST_WSTAB) && count[BWT_CNT_MSB];
  endsequence
  sequence s_run_on;
    state == BWT_ST_RUN && cpu_clk_en;
  endsequence

  a_ctrl_reset: assert property (
    $rose(rst_n) |-> ctrl == bwt_ctrl_t'(BWT_CTRL_RST)
  ) else $error("control not zero after reset");

  a_key_blocks: assert property (
    ovf && ctrl.wd_key == BWT_WD_OFF_KEY |=> !wdt_reset_req
  ) else $error("reset raised with watchdog disabled");

  a_count_clear: assert property (
    s_ctrl_write(1) |=> count == 8'h00
  ) else $error("counter not cleared by write");

  a_div_clear: assert property (
    s_ctrl_write(0) |=> !tick
  ) else $error("tick right after divider clear");

  a_count_hold: assert property (
    !tick && !sw_clr_cnt && !wake_go |=> $stable(count)
  ) else $error("counter moved without tick");

  a_wd_reset: assert property (
    tick && count == 8'hFF && state == BWT_ST_RUN && wd_en
      |=> wdt_reset_req ##1 !wdt_reset_req
  ) else $error("overflow did not request one reset pulse");

  a_wake_start: assert property (
    state == BWT_ST_STOP && ext_wake
      |=> state == BWT_ST_WSTAB && count == 8'h00 && !cpu_clk_en
  ) else $error("wake did not start stabilisation");

  a_reset_rate: assert property (
    state == BWT_ST_RSTAB |-> eff_sel == BWT_SEL_4096
  ) else $error("reset stabilisation not at slow rate");

  a_wake_rate: assert property (
    state == BWT_ST_WSTAB |-> eff_sel == ctrl.div_sel
  ) else $error("wake stabilisation ignores programmed rate");

  a_stab_end: assert property (
    s_stab_hit |=> s_run_on and stab_done
  ) else $error("stabilisation end did not free cpu clock");

  a_clk_gated: assert property (
    state != BWT_ST_RUN |-> !cpu_clk_en
  ) else $error("cpu clock on before stabilisation");

  a_irq_level: assert property (
    irq == ((stat & mask) != '0)
  ) else $error("interrupt level differs from unmasked status");
endmodule
`default_nettype wire

// ==== sim/bwt_top_tb_top.sv ====
// Purpose: self-checking bench for the base tick watchdog timer
// Assumes: shortened divider ratios 16/8/4, apb with zero or more waits
// Notes: pready, prdata and pslverr are captured at the sampling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module bwt_top_tb_top;
  import bwt_pkg::*;
  // -----------------------------------------------
  // stimulus and dut
  // -----------------------------------------------
  localparam int DS = 16;
  localparam int DM = 8;
  localparam int DF = 4;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stop_enter = 1'b0;
  logic ext_wake = 1'b0;
  logic cpu_clk_en;
  logic stab_done;
  logic wdt_reset_req;
  logic irq;
  int fail_count = 0;
  int num_checks = 0;

  bwt_top #(.DIV_SLOW(DS), .DIV_MID(DM), .DIV_FAST(DF)) uut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_enter(stop_enter), .ext_wake(ext_wake), .cpu_clk_en(cpu_clk_en),
    .stab_done(stab_done), .wdt_reset_req(wdt_reset_req), .irq(irq));

  // 100 MHz clock, period 10 ns
  initial begin
    forever #5 mclk = ~mclk;
  end

  // -----------------------------------------------
  // shared tasks
  // -----------------------------------------------
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    // answer taken at the ready edge, before the design's own updates land
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      $display("Error apb_ready expected 1 seen %0h", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {2'b00, idx}, {24'h0, d}, r, e);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b0, {2'b00, idx}, 32'h0, r, e);
    d = r[7:0];
  endtask
  // waits for stab_done (sel 0) or wdt_reset_req (sel 1), bounded
  task automatic wait_ev(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (((sel == 0) ? stab_done : wdt_reset_req) !== 1'b1 && n < lim);
  endtask
  task automatic do_reset();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // -----------------------------------------------
  // scenarios
  // -----------------------------------------------
  // reset stabilisation always at the slowest ratio, whatever was set before
  task automatic t_boot();
    int n;
    logic [7:0] v;
    `CHK("cpu_clk_en_rst", 1'b0, cpu_clk_en)
    wait_ev(0, 128 * DS + 100, n);
    `CHK("reset_stab_len", 1'b1, n >= 128 * DS - 8 && n <= 128 * DS + 20)
    @(posedge mclk);
    #1;
    `CHK("cpu_clk_en_run", 1'b1, cpu_clk_en)
    rd(BWT_IDX_CTRL, v);
    `CHK("ctrl_reset", BWT_CTRL_RST, v)
    rd(BWT_IDX_STAT, v);
    `CHK("stat_stab", 1'b1, v[BWT_EV_STAB])
    `CHK("irq_masked", 1'b0, irq)
    wr(BWT_IDX_STAT, 8'h07);
    $display("test boot done");
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    wr(BWT_IDX_CTRL, 8'hA7);
    rd(BWT_IDX_CTRL, v);
    `CHK("ctrl_readback", 8'hA4, v)
    apb(1'b0, 10'h000, 32'h0, r, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, r)
    $display("test regs done");
  endtask
  // repeated divider clears never let a tick through
  task automatic t_divclr();
    logic [7:0] v;
    wr(BWT_IDX_CTRL, 8'h03);
    repeat (15) wr(BWT_IDX_CTRL, 8'h01);
    rd(BWT_IDX_COUNT, v);
    `CHK("count_divclr", 8'h00, v)
    $display("test divclr done");
  endtask
  task automatic t_rates();
    logic [7:0] v;
    int dv;
    for (int c = 0; c < 4; c++) begin
      dv = (c == 0) ? DS : (c == 1) ? DM : DF;
      wr(BWT_IDX_CTRL, {4'hA, c[1:0], 2'b11});
      repeat (10 * dv) @(posedge mclk);
      rd(BWT_IDX_COUNT, v);
      `CHK("count_rate", 1'b1, v >= 8'd9 && v <= 8'd11)
    end
    $display("test rates done");
  endtask
  task automatic t_key();
    int seen;
    logic [7:0] v;
    seen = 0;
    wr(BWT_IDX_CTRL, 8'hAB);
    repeat (256 * DF + 100) begin
      @(posedge mclk);
      #1;
      if (wdt_reset_req === 1'b1) seen++;
    end
    `CHK("no_wdt_with_key", 0, seen)
    rd(BWT_IDX_STAT, v);
    `CHK("stat_ovf_key", 1'b1, v[BWT_EV_OVF])
    wr(BWT_IDX_STAT, 8'h02);
    $display("test key done");
  endtask
  // regular counter clears keep an enabled watchdog quiet past one wrap time
  task automatic t_service();
    int seen;
    logic [7:0] v;
    seen = 0;
    repeat (4) begin
      wr(BWT_IDX_CTRL, 8'h5A);
      repeat (128 * DF) begin
        @(posedge mclk);
        #1;
        if (wdt_reset_req === 1'b1) seen++;
      end
    end
    `CHK("no_wdt_serviced", 0, seen)
    rd(BWT_IDX_STAT, v);
    `CHK("stat_no_ovf", 1'b0, v[BWT_EV_OVF])
    $display("test service done");
  endtask
  task automatic t_overflow();
    int n;
    logic [7:0] v;
    wr(BWT_IDX_MASK, 8'h02);
    wr(BWT_IDX_CTRL, 8'h5B);
    wait_ev(1, 256 * DF + 60, n);
    `CHK("overflow_time", 1'b1, n >= 256 * DF - 6 && n <= 256 * DF + 8)
    repeat (2) @(posedge mclk);
    #1;
    `CHK("irq_ovf", 1'b1, irq)
    rd(BWT_IDX_STAT, v);
    `CHK("stat_ovf", 1'b1, v[BWT_EV_OVF])
    wr(BWT_IDX_STAT, 8'h02);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("irq_clear", 1'b0, irq)
    do_reset();
    t_boot();
    $display("test overflow done");
  endtask
  // wake from stop counts at the programmed ratio
  task automatic t_stop();
    int n;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] v;
    wr(BWT_IDX_MASK, 8'h04);
    wr(BWT_IDX_CTRL, 8'hA6);
    repeat (30) @(posedge mclk);
    stop_enter <= 1'b1;
    @(posedge mclk);
    stop_enter <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK("cpu_clk_en_stop", 1'b0, cpu_clk_en)
    rd(BWT_IDX_COUNT, c1);
    repeat (40) @(posedge mclk);
    wr(BWT_IDX_COUNT, 8'h55);
    rd(BWT_IDX_COUNT, c2);
    `CHK("count_ro_frozen", c1, c2)
    @(posedge mclk);
    ext_wake <= 1'b1;
    @(posedge mclk);
    ext_wake <= 1'b0;
    wait_ev(0, 128 * DM + 100, n);
    `CHK("wake_stab_len", 1'b1, n >= 128 * DM - 8 && n <= 128 * DM + 20)
    repeat (2) @(posedge mclk);
    #1;
    `CHK("cpu_clk_en_wake", 1'b1, cpu_clk_en)
    `CHK("irq_wake", 1'b1, irq)
    rd(BWT_IDX_STAT, v);
    `CHK("stat_wake", 1'b1, v[BWT_EV_WAKE])
    $display("test stop done");
  endtask

  // -----------------------------------------------
  // sequence, watchdog and verdict
  // -----------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    t_boot();
    t_regs();
    t_divclr();
    t_rates();
    t_key();
    t_service();
    t_overflow();
    t_stop();
    stop_test();
  end
  // well above the roughly ten thousand cycles the tests need
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
